// ---- ocm_map.svh ----
/*
  Bit positions and reset values of the output clock configuration image.
  Assumes the 128-bit image is loaded as four 32-bit words over the plain register port.
*/
`ifndef OCM_MAP_SVH
`define OCM_MAP_SVH

// ----------------------------------------------------------------------------
// Register map of the configuration port
// ----------------------------------------------------------------------------
`define OCM_CFG_WORDS      4
`define OCM_ADDR_STATUS    4'h4
`define OCM_ADDR_CODES     4'h5

// ----------------------------------------------------------------------------
// Field positions inside the 128-bit configuration image
// ----------------------------------------------------------------------------
`define OCM_POST_A_LSB     96
`define OCM_POST_B_LSB     100
`define OCM_POST_C0_LSB    104
`define OCM_POST_D0_LSB    108
`define OCM_PATH_C_DIVIDE_CODE_BANK0_LSB    112
`define OCM_PATH_D_DIVIDE_CODE_BANK0_LSB    116
`define OCM_PWRDN_LSB      120
`define OCM_MUX_A_LSB      22
`define OCM_MUX_B_LSB      46
`define OCM_MUX_C0_LSB     70
`define OCM_PATH_C_SOURCE_SEL_BANK0_LSB     124
`define OCM_MUX_D0_LSB     94
`define OCM_PATH_D_SOURCE_SEL_BANK0_LSB     126
`define OCM_LF1_BIT        20
`define OCM_LF2_BIT        44
`define OCM_LF3_B0_BIT     68
`define OCM_LF3_B1_BIT     92
`define OCM_CP1_BIT        19
`define OCM_CP2_BIT        43
`define OCM_CP3_B0_BIT     67
`define OCM_CP3_B1_BIT     91

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define OCM_CFG_RESET      32'h0000_0000

`endif

// ---- ocm_pkg.sv ----
/*
  Types shared by the output clock mux and post-divider block.
  Assumes the field positions come from ocm_map.svh.
*/
package ocm_pkg;

  typedef enum logic [1:0] {
    OCM_SRC_REF  = 2'h0,
    OCM_SRC_PLL1 = 2'h1,
    OCM_SRC_PLL2 = 2'h2,
    OCM_SRC_PLL3 = 2'h3
  } ocm_src_t;

  typedef struct packed {
    ocm_src_t   source;
    logic [3:0] divide_code;
    logic       pwrdn_en;
  } ocm_path_cfg_t;

  typedef struct packed {
    logic filter_long;
    logic pump_high;
  } ocm_pll_tune_t;

endpackage

// ---- ocm_post_divider.sv ----
/*
  One output path: source mux followed by a programmable post divider.
  Assumes the source clocks are sampled synchronously to clk as enables.
*/
`timescale 1ns/1ps

module ocm_post_divider
  import ocm_pkg::*;
#(
  parameter int CNT_W = 6
)
(
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire ocm_path_cfg_t cfg,
  input  wire logic [3:0]    src_clk,
  input  wire logic          power_down_input,
  output logic               clk_out,
  output logic [CNT_W-1:0]   ratio
);

  logic [CNT_W-1:0] count_reg;
  logic             src_d_reg;
  logic             src_now;
  logic             src_rise;
  logic             halted;

  always_comb
  begin
    unique case (cfg.divide_code)
      4'h0: ratio = CNT_W'(1);
      4'h1: ratio = CNT_W'(2);
      4'h2: ratio = CNT_W'(3);
      4'h3: ratio = CNT_W'(4);
      4'h4: ratio = CNT_W'(5);
      4'h5: ratio = CNT_W'(6);
      4'h6: ratio = CNT_W'(8);
      4'h7: ratio = CNT_W'(9);
      4'h8: ratio = CNT_W'(10);
      4'h9: ratio = CNT_W'(12);
      4'ha: ratio = CNT_W'(15);
      4'hb: ratio = CNT_W'(16);
      4'hc: ratio = CNT_W'(18);
      4'hd: ratio = CNT_W'(20);
      4'he: ratio = CNT_W'(25);
      4'hf: ratio = CNT_W'(50);
    endcase
  end

  assign src_now  = src_clk[cfg.source];
  assign src_rise = src_now & ~src_d_reg;
  assign halted   = cfg.pwrdn_en & power_down_input;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      src_d_reg <= 1'b0;
    else
      src_d_reg <= src_now;
  end

  // Toggles every ratio source edges; ratio 1 follows the source directly.
  // A change of code restarts nothing, so the output may glitch.
  always_ff @(posedge clk)
  begin
    if (sys_rst || halted)
    begin
      count_reg <= '0;
      clk_out   <= 1'b0;
    end
    else if (ratio == CNT_W'(1))
    begin
      count_reg <= '0;
      clk_out   <= src_now;
    end
    else if (src_rise || (src_now != src_d_reg))
    begin
      if (count_reg >= ratio - CNT_W'(1))
      begin
        count_reg <= '0;
        clk_out   <= ~clk_out;
      end
      else
        count_reg <= count_reg + CNT_W'(1);
    end
  end

  a_halt_low: assert property (@(posedge clk) disable iff (sys_rst)
    halted |=> !clk_out) else $error("divider output not low in power-down");

endmodule

// ---- ocm_clock_out.sv ----
/*
  Output clock path of a three-PLL generator: four muxes, four post dividers,
  banked settings for paths C and D and for the third PLL's tuning.
  Assumes the configuration image arrives over the plain register port.
*/
// The register offsets and the plain strobed port were left to the implementer.
// Function
// - Path A divide code comes from image bits 99..96.
// - Path B divide code comes from image bits 103..100.
// - Bank select low: path C divide code from bits 107..104.
// - Bank select high: path C divide code from bits 115..112.
// - Bank select low: path D divide code from bits 111..108.
// - Bank select high: path D divide code from bits 119..116.
// - Codes 0-5 divide 1-6; 6-15 divide 8,9,10,12,15,16,18,20,25,50.
// - Path A source from bits 23..22: ref, PLL1, PLL2, PLL3.
// - Path B source from bits 47..46, same encoding.
// - Bank select low: path C source from bits 71..70.
// - Bank select high: path C source from bits 125..124.
// - Bank select low: path D source from bits 95..94.
// - Bank select high: path D source from bits 127..126.
// - PLL1 and PLL2 filter constant from bits 20 and 44.
// - PLL3 holds two filter bits, 68 and 92, chosen by bank.
// - Pump current bits 19, 43, 67/91; 67 low bank, 91 high.
// - All configuration bits clear at reset; outputs pass reference.
// - Mux or divider changes may glitch the output clock.
// - Bits 120..123 power off a divider while power-down is asserted.
`timescale 1ns/1ps
`include "ocm_map.svh"

module ocm_clock_out
  import ocm_pkg::*;
#(
  parameter int CNT_W = 6
)
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        ref_clk_in,
  input  wire logic [2:0]  pll_clk_in,
  input  wire logic        bank_select_input,
  input  wire logic        power_down_input,
  output logic [3:0]       clk_out,
  output ocm_pll_tune_t    pll1_tune,
  output ocm_pll_tune_t    pll2_tune,
  output ocm_pll_tune_t    pll3_tune
);

  // --------------------------------------------------------------------------
  // Configuration image and register port
  // --------------------------------------------------------------------------
  logic [31:0]         cfg_reg [`OCM_CFG_WORDS];
  logic [127:0]        image;
  logic [3:0]          src_clk;
  ocm_path_cfg_t       path_cfg [4];
  logic [CNT_W-1:0]    ratio [4];
  logic                bank;

  genvar gi;
  generate
    for (gi = 0; gi < `OCM_CFG_WORDS; gi++)
    begin : g_word
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          cfg_reg[gi] <= `OCM_CFG_RESET;
        else if (reg_wr && reg_addr == 4'(gi))
          cfg_reg[gi] <= reg_wdata;
      end
      assign image[gi*32 +: 32] = cfg_reg[gi];
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      if (reg_addr < 4'(`OCM_CFG_WORDS))
        reg_rdata <= cfg_reg[reg_addr[1:0]];
      else if (reg_addr == `OCM_ADDR_STATUS)
        reg_rdata <= {26'h0, power_down_input, bank_select_input, clk_out};
      else if (reg_addr == `OCM_ADDR_CODES)
        reg_rdata <= {8'h0, CNT_W'(ratio[3]), CNT_W'(ratio[2]), CNT_W'(ratio[1]), CNT_W'(ratio[0])};
      else
        reg_rdata <= '0;
    end
    else
      reg_rdata <= '0;
  end

  // --------------------------------------------------------------------------
  // Field extraction with bank selection
  // --------------------------------------------------------------------------
  assign bank    = bank_select_input;
  assign src_clk = {pll_clk_in, ref_clk_in};

  always_comb
  begin
    path_cfg[0].source      = ocm_src_t'(image[`OCM_MUX_A_LSB +: 2]);
    path_cfg[0].divide_code = image[`OCM_POST_A_LSB +: 4];
    path_cfg[1].source      = ocm_src_t'(image[`OCM_MUX_B_LSB +: 2]);
    path_cfg[1].divide_code = image[`OCM_POST_B_LSB +: 4];
    if (bank)
    begin
      path_cfg[2].source      = ocm_src_t'(image[`OCM_PATH_C_SOURCE_SEL_BANK0_LSB +: 2]);
      path_cfg[2].divide_code = image[`OCM_PATH_C_DIVIDE_CODE_BANK0_LSB +: 4];
      path_cfg[3].source      = ocm_src_t'(image[`OCM_PATH_D_SOURCE_SEL_BANK0_LSB +: 2]);
      path_cfg[3].divide_code = image[`OCM_PATH_D_DIVIDE_CODE_BANK0_LSB +: 4];
    end
    else
    begin
      path_cfg[2].source      = ocm_src_t'(image[`OCM_MUX_C0_LSB +: 2]);
      path_cfg[2].divide_code = image[`OCM_POST_C0_LSB +: 4];
      path_cfg[3].source      = ocm_src_t'(image[`OCM_MUX_D0_LSB +: 2]);
      path_cfg[3].divide_code = image[`OCM_POST_D0_LSB +: 4];
    end
    for (int i = 0; i < 4; i++)
      path_cfg[i].pwrdn_en = image[`OCM_PWRDN_LSB + i];
  end

  // --------------------------------------------------------------------------
  // PLL tuning outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pll1_tune <= '0;
      pll2_tune <= '0;
      pll3_tune <= '0;
    end
    else
    begin
      pll1_tune <= '{filter_long: image[`OCM_LF1_BIT], pump_high: image[`OCM_CP1_BIT]};
      pll2_tune <= '{filter_long: image[`OCM_LF2_BIT], pump_high: image[`OCM_CP2_BIT]};
      pll3_tune <= bank ?
        '{filter_long: image[`OCM_LF3_B1_BIT], pump_high: image[`OCM_CP3_B1_BIT]} :
        '{filter_long: image[`OCM_LF3_B0_BIT], pump_high: image[`OCM_CP3_B0_BIT]};
    end
  end

  // --------------------------------------------------------------------------
  // Output paths
  // --------------------------------------------------------------------------
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_path
      ocm_post_divider #(
        .CNT_W (CNT_W)
      ) u_div (
        .clk              (clk),
        .sys_rst          (sys_rst),
        .cfg              (path_cfg[gi]),
        .src_clk          (src_clk),
        .power_down_input (power_down_input),
        .clk_out          (clk_out[gi]),
        .ratio            (ratio[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_c_bank_src: assert property (@(posedge clk) disable iff (sys_rst)
    bank |-> path_cfg[2].source == ocm_src_t'(image[125:124])) else $error("path C bank 1 source wrong");
  a_d_bank_src: assert property (@(posedge clk) disable iff (sys_rst)
    !bank |-> path_cfg[3].source == ocm_src_t'(image[95:94])) else $error("path D bank 0 source wrong");
  a_c_bank_div: assert property (@(posedge clk) disable iff (sys_rst)
    !bank |-> path_cfg[2].divide_code == image[107:104]) else $error("path C bank 0 code wrong");
  a_d_bank_div: assert property (@(posedge clk) disable iff (sys_rst)
    bank |-> path_cfg[3].divide_code == image[119:116]) else $error("path D bank 1 code wrong");
  a_top_ratio: assert property (@(posedge clk) disable iff (sys_rst)
    path_cfg[0].divide_code == 4'hf |-> ratio[0] == CNT_W'(50)) else $error("code 15 not divide 50");
  a_pll3_tune: assert property (@(posedge clk) disable iff (sys_rst)
    $stable(bank) && $stable(image) |-> pll3_tune.filter_long == (bank ? image[92] : image[68]))
    else $error("pll3 filter bank wrong");
  a_reset_clear: assert property (@(posedge clk)
    sys_rst |=> image == 128'h0) else $error("image not cleared by reset");
  a_pass_ref: assert property (@(posedge clk) disable iff (sys_rst)
    image == 128'h0 && !$past(sys_rst) |-> clk_out[1] == $past(ref_clk_in)) else $error("reference not passed");

endmodule

// ---- ocm_clk_sink.sv ----
/*
  Receiving logic of the four output clocks: measures each clock period in clk cycles.
  Assumes the clocks change only just after rising edges of clk.
*/
`timescale 1ns/1ps

module ocm_clk_sink
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] clk_in,
  output int              period [4]
);
  logic [3:0] last_reg;
  int         cnt_reg [4];

  always_ff @(posedge clk)
  begin
    last_reg <= clk_in;
    for (int i = 0; i < 4; i++)
    begin
      cnt_reg[i] <= (sys_rst || (clk_in[i] && !last_reg[i])) ? 0 : cnt_reg[i] + 1;
      if (sys_rst)
        period[i] <= 0;
      else if (clk_in[i] && !last_reg[i])
        period[i] <= cnt_reg[i] + 1;
    end
  end
endmodule

// ---- tb_top.sv ----
/*
  Self-checking bench of the output clock block: register port, sources, banks, power-down.
  Assumes ocm_pkg, ocm_clock_out and ocm_clk_sink are compiled before it.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module tb_top
  import ocm_pkg::*;
;
  logic          clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic [3:0]    reg_addr = 4'h0;
  logic [31:0]   reg_wdata = 32'h0;
  logic          reg_wr = 1'b0;
  logic          reg_rd = 1'b0;
  logic [31:0]   reg_rdata;
  logic [3:0]    src_lv = 4'h0;
  logic          bank_select_input = 1'b0;
  logic          power_down_input = 1'b0;
  logic [3:0]    clk_out;
  ocm_pll_tune_t pll1_tune, pll2_tune, pll3_tune;
  int            period [4];
  int            src_cnt [4] = '{0, 0, 0, 0};
  int            n_mismatch = 0;
  int            n_checks = 0;
  int            seed_v;
  logic [127:0]  img = 128'h0;
  logic [31:0]   rd_v;
  logic [3:0]    hi;

  // --------------------------------------------------------------
  // Clock, source clocks and instances
  // --------------------------------------------------------------
  always #5 clk = ~clk;

  // Source s has a period of 2*(s+2) clk cycles, slow enough for clean counts.
  always @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      src_cnt[i] = (src_cnt[i] + 1) % (i + 2);
      if (src_cnt[i] == 0)
        src_lv[i] <= ~src_lv[i];
    end
  end

  ocm_clock_out u_ocm_clock_out (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_clk_in(src_lv[0]), .pll_clk_in(src_lv[3:1]),
    .bank_select_input(bank_select_input), .power_down_input(power_down_input), .clk_out(clk_out),
    .pll1_tune(pll1_tune), .pll2_tune(pll2_tune), .pll3_tune(pll3_tune));
  ocm_clk_sink u_ocm_clk_sink (.clk(clk), .sys_rst(sys_rst), .clk_in(clk_out), .period(period));

  // --------------------------------------------------------------
  // Reference model and bus tasks
  // --------------------------------------------------------------
  function automatic int div_of(input logic [3:0] c);
    int tbl [16] = '{1, 2, 3, 4, 5, 6, 8, 9, 10, 12, 15, 16, 18, 20, 25, 50};
    return tbl[c];
  endfunction

  function automatic logic [3:0] code_of(input int p, input logic b);
    int lsb [2][4] = '{'{96, 100, 104, 108}, '{96, 100, 112, 116}};
    return img[lsb[b][p] +: 4];
  endfunction

  function automatic int src_of(input int p, input logic b);
    int lsb [2][4] = '{'{22, 46, 70, 94}, '{22, 46, 124, 126}};
    return int'(img[lsb[b][p] +: 2]);
  endfunction

  // The serial loader is abstracted to single-cycle word writes on the plain port.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Waits three periods of the slowest possible output, then checks periods, ratios and tuning.
  task automatic check_paths(input logic b);
    repeat (1520) @(posedge clk);
    rd(4'h5, rd_v);
    for (int p = 0; p < 4; p++)
    begin
      `CHK(period[p], div_of(code_of(p, b)) * 2 * (src_of(p, b) + 2))
      `CHK(rd_v[6 * p +: 6], 6'(div_of(code_of(p, b))))
    end
    `CHK({pll1_tune, pll2_tune}, {img[20:19], img[44:43]})
    `CHK(pll3_tune, b ? img[92:91] : img[68:67])
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #400000;
    n_mismatch++;
    tally_and_finish;
  end

  initial
  begin
    seed_v = $urandom(32'ha68420c7);
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    for (int w = 0; w < 4; w++)
    begin
      rd(w[3:0], rd_v);
      `CHK(rd_v, 32'h0)
    end
    check_paths(1'b0);
    $display("test reset_defaults done");
    for (int c = 0; c < 16; c++)
    begin
      for (int k = 0; k < 6; k++)
        img[96 + 4 * k +: 4] = 4'(c + k);
      wr(4'h3, img[127:96]);
      for (int b = 0; b < 2; b++)
      begin
        bank_select_input <= b[0];
        repeat (2) @(posedge clk);
        rd(4'h5, rd_v);
        for (int p = 0; p < 4; p++)
          `CHK(rd_v[6 * p +: 6], 6'(div_of(code_of(p, b[0]))))
      end
    end
    $display("test divide_codes done");
    for (int it = 0; it < 5; it++)
    begin
      img = {$urandom, $urandom, $urandom, $urandom};
      for (int w = 0; w < 4; w++)
        wr(w[3:0], img[32 * w +: 32]);
      for (int b = 0; b < 2; b++)
      begin
        bank_select_input <= b[0];
        check_paths(b[0]);
      end
    end
    $display("test random_paths done");
    img[123:120] = 4'h5;
    wr(4'h3, img[127:96]);
    power_down_input <= 1'b1;
    repeat (4) @(posedge clk);
    rd(4'h4, rd_v);
    `CHK(rd_v[5:4], {1'b1, bank_select_input})
    hi = 4'h0;
    repeat (1100) @(negedge clk) hi = hi | clk_out;
    `CHK(hi, 4'ha)
    power_down_input <= 1'b0;
    check_paths(bank_select_input);
    $display("test power_down done");
    wr(4'h6, 32'hffff_ffff);
    rd(4'h6, rd_v);
    `CHK(rd_v, 32'h0)
    rd(4'h3, rd_v);
    `CHK(rd_v, img[127:96])
    $display("test unmapped done");
    tally_and_finish;
  end
endmodule
